// ===== include/fbc_params.svh
// Contract
// [R1] Read: host holds chip select and output enable low, write enable high.
// [R2] Device enters array-read mode at power-up and after hardware reset.
// [R3] Device stays in array-read until a write alters its command register.
// [R4] Write: host drives write enable and chip select low, output enable high.
// [R5] After identification sequence, reads return identification codes.
// [R6] During program or erase, reads return status bits.
// [R7] Chip select high puts device in standby, outputs high impedance.
// [R8] Deselecting during program or erase does not abort the operation.
// [R9] Output enable high puts data pins in high impedance.
// [R10] Address bits 18 to 16 select one of eight 64-kilobyte sectors.
// [R11] High-voltage select read: bit 0 low maker code, high device code.
// [R12] Protection verify: sector on top bits, A1 high, A0 low; returns one or zero.
// [R13] Identification codes also readable through command register in-system.
// [R14] Device refuses program and erase on protected sectors.
// [R15] Protection changes only by high-voltage procedure, never by bus command.
// [R16] All sectors start unprotected.
// [R17] Program and erase start only after unlock cycles; host adds none, the user's plain writes must carry them.
// [R18] Below supply lockout threshold, writes are ignored and device resets.
// [R19] Control pulses under about 5 ns never start a write.
// [R20] Write inhibited when output enable low, chip select high or write enable high.
// [R21] Write conditions held at power-up give no command; array-read mode.
// [R22] Address latched on later falling edge, data on earlier rising edge.
// [R23] Wrong or out-of-order cycles return the device to array-read.
// [R24] High-voltage select and supply lockout modelled as digital flags.
`ifndef FBC_PARAMS_SVH
`define FBC_PARAMS_SVH
`define FBC_ADDR_W        19
`define FBC_DATA_W        8
`define FBC_SECT_LSB      16
`define FBC_SECT_MSB      18
`define FBC_ID_A0         0
`define FBC_ID_A1         1
`define FBC_ID_A6         6
`define FBC_PROT_YES      8'h01
`define FBC_SETUP_NS      20
`define FBC_PULSE_NS      40
`define FBC_HOLD_NS       20
`define FBC_ACCESS_NS     80
`define FBC_CLK_NS        4
`define FBC_MIN_CYC       1
`endif

// ===== include/fbc_pkg.sv
package fbc_pkg;
	typedef enum logic [1:0] {FBC_OP_READ, FBC_OP_WRITE, FBC_OP_ID, FBC_OP_PROT} fbc_op_t;
	typedef struct packed {
		fbc_op_t    op;
		logic [18:0] addr;
		logic [7:0]  data;
	} fbc_req_t;
	typedef struct packed {
		logic       ce_b;
		logic       oe_b;
		logic       we_b;
	} fbc_ctl_t;
endpackage : fbc_pkg

// ===== rtl/fbc_host.sv
`timescale 1ns/1ns
`include "fbc_params.svh"
// Host-side bus controller for a byte-wide asynchronous parallel flash
module fbc_host
	import fbc_pkg::*;
#(
	parameter int SETUP_CYC  = (`FBC_SETUP_NS + `FBC_CLK_NS - 1) / `FBC_CLK_NS,
	parameter int PULSE_CYC  = (`FBC_PULSE_NS + `FBC_CLK_NS - 1) / `FBC_CLK_NS,
	parameter int HOLD_CYC   = (`FBC_HOLD_NS + `FBC_CLK_NS - 1) / `FBC_CLK_NS,
	parameter int ACCESS_CYC = (`FBC_ACCESS_NS + `FBC_CLK_NS - 1) / `FBC_CLK_NS
) (
	// Clock and reset
	input  wire logic                    clk_i,
	input  wire logic                    rst_b_i,
	// User request port
	input  wire logic                    req_valid_i,
	input  wire fbc_req_t                req_i,
	input  wire logic [2:0]              req_sector_i,
	output logic                         req_ready_o,
	output logic                         rsp_valid_o,
	output logic [`FBC_DATA_W-1:0]       rsp_data_o,
	output logic                         rsp_prot_o,
	// Flags modelled as digital levels
	input  wire logic                    supply_low_i,
	output logic                         high_voltage_id_select_o,
	// Flash pins
	output logic                         ce_b_o,
	output logic                         oe_b_o,
	output logic                         we_b_o,
	output logic [`FBC_ADDR_W-1:0]       addr_o,
	output logic [`FBC_DATA_W-1:0]       data_bus_o,
	output logic                         data_bus_oe_b_o,
	input  wire logic [`FBC_DATA_W-1:0]  data_bus_i
);
	// ==========================================================
	// Pin synchronisers
	// ==========================================================
	logic [`FBC_DATA_W:0] sync_q;
	fbc_sync #(.W(`FBC_DATA_W + 1)) u_sync (
		.clk_i  (clk_i),
		.rst_b_i(rst_b_i),
		.d_i    ({supply_low_i, data_bus_i}),
		.q_o    (sync_q)
	);
	wire                   supply_low = sync_q[`FBC_DATA_W]; // [R24]
	wire [`FBC_DATA_W-1:0] rd_data    = sync_q[`FBC_DATA_W-1:0];

	// ==========================================================
	// Sequencer
	// ==========================================================
	typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_PULSE, ST_HOLD, ST_DONE} fbc_state_t;
	fbc_state_t state;
	fbc_state_t next_state;
	logic [7:0] cnt;
	logic [7:0] next_cnt;
	fbc_req_t   cur;
	fbc_ctl_t   ctl;
	fbc_ctl_t   next_ctl;

	wire is_write = (cur.op == FBC_OP_WRITE);
	// Supply lockout means the flash drops writes, so hold writes off
	// Unlock cycles are the user's plain writes, sent in the order given
	wire accept   = req_valid_i && (state == ST_IDLE) // [R17]
	                && !(supply_low && req_i.op == FBC_OP_WRITE); // [R18]
	wire [7:0] pulse_len = is_write ? 8'(PULSE_CYC) : 8'(ACCESS_CYC + 2);
	wire       cnt_done  = (cnt == 8'h00);

	// Address: identification reads fix A1, A6; protection reads fix A0, A1, A6 and the sector bits
	logic [`FBC_ADDR_W-1:0] next_addr;
	always_comb
	begin
		next_addr = req_i.addr;
		if (req_i.op == FBC_OP_ID || req_i.op == FBC_OP_PROT)
		begin
			next_addr[`FBC_ID_A6] = 1'b0; // [R11]
			next_addr[`FBC_ID_A1] = (req_i.op == FBC_OP_PROT); // [R12]
			if (req_i.op == FBC_OP_PROT)
			begin
				next_addr[`FBC_ID_A0] = 1'b0;
				next_addr[`FBC_SECT_MSB:`FBC_SECT_LSB] = req_sector_i; // [R10] [R12]
			end
		end
	end

	always_comb
	begin
		next_state = state;
		next_cnt   = cnt_done ? cnt : cnt - 8'h01;
		next_ctl   = ctl;
		unique case (state)
			ST_IDLE:
			begin
				next_ctl = '{ce_b: 1'b1, oe_b: 1'b1, we_b: 1'b1}; // [R7]
				if (accept)
				begin
					next_state = ST_SETUP;
					next_cnt   = 8'(SETUP_CYC);
					next_ctl.ce_b = 1'b0;
				end
			end
			ST_SETUP:
				if (cnt_done)
				begin
					next_state = ST_PULSE;
					next_cnt   = pulse_len;
					// Write: oe high, we low; read: oe low, we high
					next_ctl.oe_b = is_write; // [R1] [R4] [R20]
					next_ctl.we_b = !is_write; // [R22]
				end
			ST_PULSE:
				if (cnt_done)
				begin
					next_state = ST_HOLD;
					next_cnt   = 8'(HOLD_CYC);
					next_ctl.we_b = 1'b1; // [R22]
					next_ctl.oe_b = 1'b1; // [R9]
				end
			ST_HOLD:
				if (cnt_done)
				begin
					next_state = ST_DONE;
					next_ctl.ce_b = 1'b1;
				end
			ST_DONE:
				next_state = ST_IDLE;
		endcase
	end

	// Pulse width far above 5 ns keeps clear of the glitch filter
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			state <= ST_IDLE;
			cnt   <= 8'h00;
			ctl   <= '{ce_b: 1'b1, oe_b: 1'b1, we_b: 1'b1}; // [R21]
			cur   <= '0;
		end
		else
		begin
			state <= next_state;
			cnt   <= next_cnt;
			ctl   <= next_ctl; // [R19]
			if (accept)
				cur <= '{op: req_i.op, addr: next_addr, data: req_i.data};
		end
	end

	// ==========================================================
	// Pin and response registers
	// ==========================================================
	// Read data is sampled at the last pulse cycle, past the sync delay
	wire sample = (state == ST_PULSE) && cnt_done && !is_write;
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			ce_b_o                   <= 1'b1;
			oe_b_o                   <= 1'b1;
			we_b_o                   <= 1'b1;
			addr_o                   <= '0;
			data_bus_o               <= '0;
			data_bus_oe_b_o          <= 1'b1;
			high_voltage_id_select_o <= 1'b0;
			req_ready_o              <= 1'b0;
			rsp_valid_o              <= 1'b0;
			rsp_data_o               <= '0;
			rsp_prot_o               <= 1'b0;
		end
		else
		begin
			ce_b_o          <= next_ctl.ce_b;
			oe_b_o          <= next_ctl.oe_b;
			we_b_o          <= next_ctl.we_b;
			addr_o          <= accept ? next_addr : addr_o;
			data_bus_o      <= accept ? req_i.data : data_bus_o;
			// Drive data only while a write owns the bus
			data_bus_oe_b_o <= !((next_state != ST_IDLE) && (next_state != ST_DONE)
			                    && (accept ? req_i.op == FBC_OP_WRITE : is_write)); // [R4]
			high_voltage_id_select_o <= (next_state != ST_IDLE) && (next_state != ST_DONE)
			                    && (accept ? (req_i.op == FBC_OP_ID || req_i.op == FBC_OP_PROT)
			                               : (cur.op == FBC_OP_ID || cur.op == FBC_OP_PROT));
			req_ready_o     <= (next_state == ST_IDLE);
			rsp_valid_o     <= sample;
			if (sample)
			begin
				rsp_data_o <= rd_data; // [R5] [R6]
				rsp_prot_o <= (cur.op == FBC_OP_PROT) && (rd_data == `FBC_PROT_YES); // [R12]
			end
		end
	end
endmodule : fbc_host

// ===== rtl/fbc_sync.sv
`timescale 1ns/1ns
// Two-stage synchroniser for pin inputs
module fbc_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_i,
	input  wire logic         rst_b_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	logic [W-1:0] meta;
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			meta <= '0;
			q_o  <= '0;
		end
		else
		begin
			meta <= d_i;
			q_o  <= meta;
		end
	end
endmodule : fbc_sync

// ===== test/fbc_flash_model.sv
`timescale 1ns/1ns
// ==========
// Flash device model
module fbc_flash_model #(
	parameter logic [7:0] MAKER_CODE = 8'h5A, // Arbitrary value
	parameter logic [7:0] DEV_CODE   = 8'h3C, // Arbitrary value
	// One bit per sector, set only by programming equipment
	parameter logic [7:0] PROT_MASK  = 8'h00
) (
	// Pins
	input  wire logic        ce_b_i,
	input  wire logic        oe_b_i,
	input  wire logic        we_b_i,
	input  wire logic        hv_i,
	input  wire logic [18:0] addr_i,
	input  wire logic [7:0]  data_i,
	output logic      [7:0]  data_o
);
	int          wr_count = 0;
	logic [7:0]  wr_data  = 8'h00;
	logic [18:0] wr_addr  = '0;
	realtime     we_fall  = 0;
	logic [7:0]  last     = 8'h00;
	wire         prot     = PROT_MASK[addr_i[18:16]];
	wire        rd       = !ce_b_i && !oe_b_i && we_b_i;
	wire  [7:0] id_q     = addr_i[0] ? DEV_CODE : MAKER_CODE;
	// No command decoding: the model never leaves array read
	wire  [7:0] q        = !hv_i ? ~addr_i[7:0] : addr_i[1] ? {7'h00, prot} : id_q;
	// Released bus shows the inverse so a stale byte never passes
	assign data_o = rd ? q : ~last;
	always @(q or rd)
		if (rd)
			last = q;
	always @(negedge we_b_i)
		if (!ce_b_i)
		begin
			we_fall = $realtime;
			wr_addr = addr_i;
		end
	// Strobes shorter than the glitch filter are not writes
	always @(posedge we_b_i)
		if (!ce_b_i && oe_b_i && ($realtime - we_fall) >= 5.0)
		begin
			wr_count++;
			wr_data = data_i;
		end
endmodule : fbc_flash_model

// ===== test/fbc_host_monitor.sv
`timescale 1ns/1ns
// ==========
// Pin checker
module fbc_host_mon
	import fbc_pkg::*;
(
	input wire logic        clk_i,
	input wire logic        rst_b_i,
	input wire logic        req_valid_i,
	input wire fbc_req_t    req_i,
	input wire logic        req_ready_o,
	input wire logic        rsp_valid_o,
	input wire logic        supply_low_i,
	input wire logic        high_voltage_id_select_o,
	input wire logic        ce_b_o,
	input wire logic        oe_b_o,
	input wire logic        we_b_o,
	input wire logic [18:0] addr_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	wire rd_take = req_valid_i && req_ready_o && req_i.op == FBC_OP_READ;
	read_ctl_a: assert property (!oe_b_o |-> !ce_b_o && we_b_o)
		else $error("read strobes wrong");
	write_ctl_a: assert property (!we_b_o |-> !ce_b_o && oe_b_o)
		else $error("write strobes wrong");
	idle_standby_a: assert property (req_ready_o |-> ce_b_o && oe_b_o && we_b_o)
		else $error("idle not deselected");
	read_take_a: assert property (rd_take |=> !req_ready_o)
		else $error("ready kept after take");
	read_answer_a: assert property (rd_take |-> ##[2:60] rsp_valid_o)
		else $error("no read answer");
	id_addr_a: assert property (high_voltage_id_select_o && !oe_b_o |-> !addr_o[6])
		else $error("id read with A6 high");
	prot_addr_a: assert property (high_voltage_id_select_o && !oe_b_o && addr_o[1] |-> !addr_o[0])
		else $error("prot read with A0 high");
	we_width_a: assert property ($fell(we_b_o) |-> !we_b_o [*2])
		else $error("write pulse too short");
	lockout_a: assert property (supply_low_i [*4] ##0 req_valid_i && req_ready_o
		&& req_i.op == FBC_OP_WRITE |=> req_ready_o)
		else $error("write taken in lockout");
	cover property (rsp_valid_o);
	cover property ($fell(we_b_o));
	cover property (high_voltage_id_select_o && !oe_b_o);
endmodule : fbc_host_mon
bind fbc_host fbc_host_mon fbc_host_mon_inst (.clk_i(clk_i), .rst_b_i(rst_b_i),
	.req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(req_ready_o),
	.rsp_valid_o(rsp_valid_o), .supply_low_i(supply_low_i), .ce_b_o(ce_b_o),
	.high_voltage_id_select_o(high_voltage_id_select_o), .oe_b_o(oe_b_o),
	.we_b_o(we_b_o), .addr_o(addr_o));

// ===== test/test_fbc_host.sv
`timescale 1ns/1ns
`define CHK(a, e, m) begin total_checks++; if ((a) !== (e)) begin err_count++; \
	$display("[FAIL] %0t %s", $time, m); end end
// ==========
// Bench top
module test_fbc_host
	import fbc_pkg::*;
;
	logic clk_i = 0, rst_b_i = 0, req_valid_i = 0, supply_low_i = 0;
	fbc_req_t req_i = '0;
	logic [2:0] req_sector_i = '0;
	logic req_ready_o, rsp_valid_o, rsp_prot_o, hv, ce_b, oe_b, we_b, dq_oe_b;
	logic [7:0] rsp_data_o, dq_o, flash_q;
	logic [18:0] addr;
	int err_count = 0, total_checks = 0, n;
	wire [7:0] bus = !dq_oe_b ? dq_o : flash_q;
	always #2 clk_i = ~clk_i;
	fbc_host #(.SETUP_CYC(2), .PULSE_CYC(3), .HOLD_CYC(2), .ACCESS_CYC(4)) fbc_host_inst (
		.clk_i(clk_i), .rst_b_i(rst_b_i), .req_valid_i(req_valid_i), .req_i(req_i),
		.req_sector_i(req_sector_i), .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o),
		.rsp_data_o(rsp_data_o), .rsp_prot_o(rsp_prot_o), .supply_low_i(supply_low_i),
		.high_voltage_id_select_o(hv), .ce_b_o(ce_b), .oe_b_o(oe_b), .we_b_o(we_b),
		.addr_o(addr), .data_bus_o(dq_o), .data_bus_oe_b_o(dq_oe_b), .data_bus_i(bus));
	fbc_flash_model #(.PROT_MASK(8'h20)) fbc_flash_model_inst (.ce_b_i(ce_b), .oe_b_i(oe_b),
		.we_b_i(we_b), .hv_i(hv), .addr_i(addr), .data_i(bus), .data_o(flash_q));
	task req(input fbc_op_t op, input logic [18:0] a, input logic [7:0] d, input logic [2:0] s);
		repeat (40) if (req_ready_o !== 1'b1) @(posedge clk_i) #1;
		req_valid_i = 1;
		req_i = '{op, a, d};
		req_sector_i = s;
		@(posedge clk_i) #1;
		req_valid_i = 0;
	endtask : req
	task rd_chk(input fbc_op_t op, input logic [18:0] a, input logic [2:0] s, input logic [7:0] e);
		req(op, a, 8'h00, s);
		repeat (60) if (rsp_valid_o !== 1'b1) @(posedge clk_i) #1;
		`CHK(rsp_data_o, e, "read data")
	endtask : rd_chk
	task finish_test;
		if (err_count == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : finish_test
	initial begin
		repeat (12) @(posedge clk_i);
		#1 rst_b_i = 1;
		@(posedge clk_i) #1;
		rd_chk(FBC_OP_READ, 19'h0_FFFF, 0, 8'h00);
		rd_chk(FBC_OP_READ, 19'h7_0000, 0, 8'hFF);
		rd_chk(FBC_OP_ID, 19'h0_0000, 0, 8'h5A);
		rd_chk(FBC_OP_ID, 19'h0_0001, 0, 8'h3C);
		for (int i = 0; i < 8; i++) begin
			rd_chk(FBC_OP_PROT, 19'h0_0000, i[2:0], (i == 5) ? 8'h01 : 8'h00);
			`CHK(rsp_prot_o, (i == 5), "prot flag")
		end
		supply_low_i = 1;
		repeat (4) @(posedge clk_i) #1;
		n = fbc_flash_model_inst.wr_count;
		req(FBC_OP_WRITE, 19'h0_0555, 8'hAA, 0);
		repeat (20) @(posedge clk_i) #1;
		`CHK(fbc_flash_model_inst.wr_count, n, "write in lockout")
		`CHK(req_ready_o, 1'b1, "ready in lockout")
		supply_low_i = 0;
		repeat (4) @(posedge clk_i) #1;
		req(FBC_OP_WRITE, 19'h0_0555, 8'hAA, 0);
		req(FBC_OP_READ, 19'h0_0000, 8'h00, 0);
		`CHK(fbc_flash_model_inst.wr_count, n + 1, "write count")
		`CHK(fbc_flash_model_inst.wr_data, 8'hAA, "write data")
		`CHK(fbc_flash_model_inst.wr_addr, 19'h0_0555, "write address")
		finish_test;
	end
	initial begin
		#80000;
		err_count++;
		finish_test;
	end
endmodule : test_fbc_host
